// ==== pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Stands for the two timer input pins. They are push-pull inputs of the
// device, so they keep their level between edges rather than float.
module pin_model
(
	input wire logic clk,
	output logic pin0,
	output logic pin3
);
	// Both pins idle low from time zero.
	initial
	begin
		pin0 = 1'b0;
		pin3 = 1'b0;
	end

	// Moves one pin just after an edge, then holds it long enough for the
	// synchroniser and edge detector to settle before anything else moves.
	task automatic drive(input logic ch, input logic lvl, input int hold);
		@(posedge clk);
		if (ch)
			pin3 <= lvl;
		else
			pin0 <= lvl;
		repeat (hold) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_mode_defs.svh"

module tb_top;
	typedef struct packed {
		logic [31:0] data;
		logic [31:0] mask;
		logic [1:0] resp;
	} note_t;
	logic SYS_CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	logic ARVALID = 1'b0, RREADY = 1'b0;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic [3:0] WSTRB = 4'h3;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, out0, int0, pin0, pin3;
	logic out3, int3;
	logic [1:0] BRESP, RRESP;
	logic [31:0] RDATA, rv;
	int errors = 0, num_checks = 0, cyc = 0, n0 = 0, n3 = 0, rc;
	integer seed = 32'hced319a6;
	note_t rq[$], bq[$], nt;

	timer_channel_mode_config timer_channel_mode_config_inst
	(
		.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.CH0_TIMER_INPUT(pin0), .CH3_TIMER_INPUT(pin3),
		.CH0_TIMER_OUT(out0), .CH3_TIMER_OUT(out3),
		.CH0_TIMER_INT(int0), .CH3_TIMER_INT(int3)
	);

	pin_model pin_model_inst (.clk(SYS_CLK), .pin0(pin0), .pin3(pin3));

	// A 50 MHz system clock.
	initial
	begin
		forever #10 SYS_CLK = ~SYS_CLK;
	end

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Offsets above the last register answer with an error.
	function automatic logic [1:0] rsp(input logic [7:0] a);
		return (a > 8'h20) ? `RESP_SLVERR : `RESP_OKAY;
	endfunction

	function automatic logic [15:0] mword(input logic [1:0] ck,
		input logic src, input logic sp, input logic [2:0] tr,
		input logic [1:0] ed, input logic [3:0] mo);
		return {ck, 1'b0, src, sp, tr, ed, 2'b00, mo};
	endfunction

	function automatic logic [7:0] maddr(input logic c);
		return c ? `OFS_CH3_MODE : `OFS_CH0_MODE;
	endfunction

	// Readiness is looked at mid-cycle, so the handshake edge is never raced.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic ta, tw, aw, w, b;
		bq.push_back('{32'h0, 32'h0, rsp(a)});
		@(posedge SYS_CLK);
		AWADDR <= a;
		WDATA <= {16'h0000, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		b = 1'b0;
		while (!(aw && w))
		begin
			@(negedge SYS_CLK);
			ta = AWVALID && AWREADY === 1'b1;
			tw = WVALID && WREADY === 1'b1;
			@(posedge SYS_CLK);
			if (ta)
				AWVALID <= 1'b0;
			if (tw)
				WVALID <= 1'b0;
			aw = aw | ta;
			w = w | tw;
		end
		while (!b)
		begin
			@(negedge SYS_CLK);
			b = BVALID === 1'b1;
			@(posedge SYS_CLK);
		end
		BREADY <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		logic b;
		rq.push_back('{e, m, rsp(a)});
		@(posedge SYS_CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge SYS_CLK);
			b = ARREADY === 1'b1;
			@(posedge SYS_CLK);
		end
		ARVALID <= 1'b0;
		b = 1'b0;
		while (!b)
		begin
			@(negedge SYS_CLK);
			b = RVALID === 1'b1;
			rv = RDATA;
			rc = cyc;
			@(posedge SYS_CLK);
		end
		RREADY <= 1'b0;
	endtask

	// The short step lets the interrupt counters settle before any read.
	task automatic pause(input int n);
		repeat (n) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
		#1;
	endtask

	// A prohibited mode parks the channel, which is the cheapest stop.
	task automatic stop(input logic c);
		wr(maddr(c), 16'h0002);
	endtask

	task automatic start(input logic c);
		wr(`OFS_SW_START, c ? 16'h0002 : 16'h0001);
	endtask

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask

	// Pairs each bus answer with the oldest note and counts interrupts.
	always @(negedge SYS_CLK)
	begin
		n0 <= n0 + int'(int0 === 1'b1);
		n3 <= n3 + int'(int3 === 1'b1);
		if (RVALID === 1'b1 && RREADY && rq.size() > 0)
		begin
			nt = rq.pop_front();
			chk("read data", RDATA & nt.mask, nt.data & nt.mask);
			chk("read resp", {30'h0, RRESP}, {30'h0, nt.resp});
		end
		if (BVALID === 1'b1 && BREADY && bq.size() > 0)
		begin
			nt = bq.pop_front();
			chk("write resp", {30'h0, BRESP}, {30'h0, nt.resp});
		end
	end

	// The ceiling is several times the expected run length.
	always @(posedge SYS_CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			errors++;
			summarize();
		end
	end

	initial
	begin
		int k, p, d, s;
		int lst[8];
		logic c;
		logic [1:0] e;
		logic [15:0] r, dn;
		logic [31:0] c1;
		lst = '{0, 1, 2, 4, 5, 8, 9, 12};
		repeat (16) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		rd(`OFS_CH0_MODE, 32'h0, 32'hffffffff);
		rd(`OFS_CH3_MODE, 32'h0, 32'hffffffff);
		wr(`OFS_CH0_MODE, 16'hffff);
		rd(`OFS_CH0_MODE, 32'hd7cf, 32'hffffffff);
		wr(`OFS_CH3_MODE, 16'hffff);
		rd(`OFS_CH3_MODE, 32'hdfcf, 32'hffffffff);
		wr(8'h24, 16'h0001);
		rd(8'h24, 32'h0, 32'hffffffff);
		done("registers");
		for (k = 0; k < 24; k++)
		begin
			s = k % 16;
			if (k < 16)
				wr(`OFS_CH0_MODE, mword(0, 0, 0, 0, 0, s[3:0]));
			else
				wr(`OFS_CH0_MODE, mword(0, 0, 0, s[2:0], 0, 0));
			p = (k < 16) ? !(s inside {0, 1, 4, 5, 6, 8, 9, 12})
				: !(s inside {0, 1, 2, 4});
			rd(`OFS_STATUS, 32'(p), 32'h1);
		end
		done("decode");
		wr(`OFS_CH0_DATA, 16'h0100);
		for (k = 0; k < 8; k++)
		begin
			stop(1'b0);
			wr(`OFS_CH0_MODE, mword(0, 0, 0, 0, 0, lst[k][3:0]));
			pause(1);
			p = n0;
			c = out0;
			start(1'b0);
			pause(4);
			d = (lst[k] == 1 || lst[k] == 5);
			if (lst[k] < 8 || lst[k] == 12)
			begin
				chk("start irq", 32'(n0 - p), 32'(d));
				chk("start out", {31'h0, out0}, {31'h0, c ^ d[0]});
			end
			rd(`OFS_STATUS, (lst[k] == 2) ? 32'h0 : 32'h8, 32'h8);
			rd(`OFS_COUNTERS, 32'h0, 32'h0);
			c1 = rv;
			pause(4);
			rd(`OFS_COUNTERS, 32'h0, 32'h0);
			if (lst[k] != 2)
				chk("count up", {31'h0, rv[15:0] > c1[15:0]},
					{31'h0, lst[k] inside {4, 5, 12}});
			if (lst[k] >= 4)
			begin
				p = n0;
				start(1'b0);
				pause(4);
				chk("retrigger irq", 32'(n0 - p), 32'(lst[k] != 8));
				rd(`OFS_CAPTURES, 32'h0, 32'h0);
				if (lst[k] inside {4, 5, 12})
					chk("capture", {31'h0, rv[15:0] != 16'h0}, 32'h1);
			end
		end
		done("modes");
		for (k = 0; k < 6; k++)
		begin
			c = k[0];
			e = 2'(k / 2);
			r = 16'(16 + ($unsigned($random(seed)) % 16));
			s = 5 + ($unsigned($random(seed)) % 4);
			stop(c);
			wr(c ? `OFS_CH3_DATA : `OFS_CH0_DATA, r);
			wr(maddr(c), mword(0, 1'b1, 0, 0, e, 4'h6));
			start(c);
			repeat (3)
			begin
				pin_model_inst.drive(c, 1'b1, s);
				pin_model_inst.drive(c, 1'b0, s);
			end
			dn = r - ((e == 2'b10) ? 16'd6 : 16'd3);
			rd(`OFS_COUNTERS, {dn, dn},
				c ? 32'hffff0000 : 32'h0000ffff);
		end
		done("events");
		for (k = 0; k < 3; k++)
		begin
			stop(1'b0);
			wr(`OFS_CH0_MODE, mword(0, 0, 0, k[2:0], 2'b00, 4'h0));
			pin_model_inst.drive(1'b0, 1'b1, 6);
			rd(`OFS_STATUS, (k == 2) ? 32'h8 : 32'h0, 32'h8);
			pin_model_inst.drive(1'b0, 1'b0, 6);
			rd(`OFS_STATUS, (k != 0) ? 32'h8 : 32'h0, 32'h8);
		end
		done("triggers");
		wr(`OFS_PRESCALER, 16'h3210);
		for (k = 0; k < 8; k++)
		begin
			c = k[2];
			s = (k % 4 == 1) ? 2 : (k % 4 == 2) ? 1 : k % 4;
			stop(c);
			wr(c ? `OFS_CH3_DATA : `OFS_CH0_DATA, 16'hf000);
			wr(maddr(c), mword(k[1:0], 0, 0, 0, 0, 4'h0));
			start(c);
			rd(`OFS_COUNTERS, 32'h0, 32'h0);
			c1 = c ? rv[31:16] : rv[15:0];
			p = rc;
			pause(40);
			rd(`OFS_COUNTERS, 32'h0, 32'h0);
			dn = c1[15:0] - (c ? rv[31:16] : rv[15:0]) + 16'd1;
			dn = dn - 16'((rc - p) >> s);
			chk("tick rate", {31'h0, dn <= 16'd2}, 32'h1);
		end
		done("taps");
		stop(1'b1);
		wr(`OFS_CH3_DATA, 16'h1234);
		wr(`OFS_CH3_MODE, mword(0, 0, 1'b1, 3'b100, 0, 4'h0));
		stop(1'b0);
		wr(`OFS_CH0_DATA, 16'h0100);
		wr(`OFS_CH0_MODE, mword(0, 0, 0, 0, 0, 4'h1));
		rd(`OFS_STATUS, 32'h0, 32'h80);
		start(1'b0);
		pause(4);
		rd(`OFS_STATUS, 32'h80, 32'h80);
		rd(`OFS_COUNTERS, 32'h0, 32'hff000000);
		c = out3;
		p = n3;
		pause(120);
		chk("split irq", {31'h0, n3 > p}, 32'h1);
		chk("split out", {31'h0, out3}, {31'h0, c ^ 1'(n3 - p)});
		done("slave split");
		summarize();
	end
endmodule

`default_nettype wire

// ==== timer_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_mode_defs.svh"

module timer_channel
(
	input wire logic clk,
	input wire logic rst_n,
	input wire timer_mode_pkg::mode_reg_t cfg,
	input wire logic [15:0] reload,
	input wire logic tick,
	input wire logic sw_start,
	input wire logic hw_trig,
	output logic [15:0] count,
	output logic [15:0] capture,
	output timer_mode_pkg::chan_stat_t stat
);

	timer_mode_pkg::op_mode_t op;
	logic valid, start, low, up_mode;
	logic idle_start, retrig, cap_ev, tick_ev, expire, start_irq;
	logic [15:0] mask, count_q, cap_q;
	logic counting_q, irq_q, out_q;

	// Mode decode and the events that move the counter.
	always_comb
	begin
		op = timer_mode_pkg::decode_mode(cfg);
		valid = (op != timer_mode_pkg::MODE_BAD) &&
			timer_mode_pkg::trig_ok(cfg);
		low = cfg.mode_low_bit;
		mask = cfg.width_split ? `SPLIT_MASK : `FULL_MASK;
		up_mode = (op == timer_mode_pkg::MODE_CAPTURE) ||
			(op == timer_mode_pkg::MODE_CAP_ONE);
		start = sw_start | hw_trig;
		idle_start = valid && start && !counting_q;
		retrig = valid && start && counting_q &&
			(op == timer_mode_pkg::MODE_ONE_COUNT) && low;
		cap_ev = valid && start && counting_q && up_mode;
		tick_ev = valid && counting_q && tick && !retrig && !cap_ev;
		expire = tick_ev && !up_mode && ((count_q & mask) == 16'h0000);
		start_irq = idle_start && low && !up_mode ? 
			(op == timer_mode_pkg::MODE_INTERVAL) :
			idle_start && low && (op == timer_mode_pkg::MODE_CAPTURE);
	end

	// Counter: down in interval, event and one-count, up in capture modes.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= 16'h0000;
		else if (idle_start || retrig || cap_ev)
			count_q <= up_mode ? 16'h0000 : (reload & mask);
		else if (tick_ev && up_mode)
			count_q <= (count_q + 16'h0001) & mask;
		else if (expire)
			count_q <= reload & mask;
		else if (tick_ev)
			count_q <= (count_q - 16'h0001) & mask;
	end

	// Counting flag; a bad setting parks the channel until fixed.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			counting_q <= 1'b0;
		else if (!valid)
			counting_q <= 1'b0;
		else if (idle_start)
			counting_q <= 1'b1;
		else if (cap_ev && op == timer_mode_pkg::MODE_CAP_ONE)
			counting_q <= 1'b0;
		else if (expire && op == timer_mode_pkg::MODE_ONE_COUNT)
			counting_q <= 1'b0;
	end

	// Interrupt pulse, output toggle and captured value.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_q <= 1'b0;
			out_q <= 1'b0;
			cap_q <= 16'h0000;
		end
		else
		begin
			irq_q <= start_irq || retrig || cap_ev || expire;
			if (start_irq || expire)
				out_q <= !out_q;
			if (cap_ev)
				cap_q <= count_q;
		end
	end

	assign count = count_q;
	assign capture = cap_q;
	assign stat = '{counting: counting_q, irq: irq_q, out: out_q,
		prohibited: !valid};

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_bad_setting_idle: assert property (!valid |=> !counting_q && !irq_q)
		else $error("channel ran on a prohibited setting");
	a_one_count_hold: assert property (
		counting_q && op == timer_mode_pkg::MODE_ONE_COUNT && !low &&
		start && !expire && valid |=> !irq_q && counting_q &&
		(count_q == $past(count_q) ||
		count_q == $past(count_q) - 16'h0001))
		else $error("one-count accepted a start while counting");
	a_interval_down: assert property (
		tick_ev && op == timer_mode_pkg::MODE_INTERVAL && !expire &&
		!cfg.width_split |=> count_q == $past(count_q) - 16'h0001)
		else $error("interval counter did not count down");
	a_capture_up: assert property (
		tick_ev && op == timer_mode_pkg::MODE_CAPTURE && !cfg.width_split
		|=> count_q == $past(count_q) + 16'h0001)
		else $error("capture counter did not count up");
	a_start_irq: assert property (
		idle_start && op == timer_mode_pkg::MODE_INTERVAL
		|=> irq_q == $past(low) && out_q == ($past(out_q) ^ $past(low)))
		else $error("start interrupt wrong for low mode bit");
	a_retrig_irq: assert property (retrig |=> irq_q && counting_q)
		else $error("retrigger raised no interrupt");
	a_cap_one_quiet: assert property (
		idle_start && op == timer_mode_pkg::MODE_CAP_ONE
		|=> !irq_q && $stable(out_q) && count_q == 16'h0000)
		else $error("capture and one-count acted at start");

endmodule
`default_nettype wire

// ==== timer_channel_mode_config.sv ====
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_mode_defs.svh"

module timer_channel_mode_config
(
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic CH0_TIMER_INPUT,
	input wire logic CH3_TIMER_INPUT,
	output logic CH0_TIMER_OUT,
	output logic CH3_TIMER_OUT,
	output logic CH0_TIMER_INT,
	output logic CH3_TIMER_INT
);

	// Index 0 is channel 0 and index 1 is channel 3 throughout.
	localparam int NCH = 2;
	localparam int PW = `PRESCALER_BITS;

	logic [15:0] prescaler_select_q;
	logic [15:0] mode_q [NCH];
	logic [15:0] data_q [NCH];
	logic [NCH-1:0] sw_start_q;
	logic [PW-1:0] presc_q;
	logic [3:0] tap_en;
	logic [NCH-1:0] pin, sync1_q, sync2_q, prev_q;
	logic [NCH-1:0] rise, fall, valid_edge, hw_trig, count_en;
	timer_mode_pkg::mode_reg_t cfg [NCH];
	timer_mode_pkg::chan_stat_t stat [NCH];
	logic [15:0] count [NCH];
	logic [15:0] capture [NCH];
	logic [7:0] aw_addr_q;
	logic aw_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic w_have_q;
	logic do_write;

	// Whether an address names a register of this block.
	function automatic logic reg_known(input logic [7:0] a);
		case (a)
			`OFS_PRESCALER, `OFS_CH0_MODE, `OFS_CH3_MODE, `OFS_SW_START,
			`OFS_CH0_DATA, `OFS_CH3_DATA, `OFS_STATUS, `OFS_COUNTERS,
			`OFS_CAPTURES: reg_known = 1'b1;
			default: reg_known = 1'b0;
		endcase
	endfunction

	// Merges a 16-bit register with the two low byte lanes of a write.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction

	// True on the cycles where a tap whose field is sel fires.
	function automatic logic tap_pulse(input logic [PW-1:0] cnt,
		input logic [3:0] sel);
		logic [15:0] m;
		m = (16'h0001 << sel) - 16'h0001;
		tap_pulse = ({1'b0, cnt} & m) == m;
	endfunction

	// Operation clock select: the two bits pick the tap in swapped order.
	function automatic logic [1:0] opclk_tap(input logic [1:0] sel);
		opclk_tap = {sel[0], sel[1]};
	endfunction

	// AXI4-Lite write side: address and data are latched in either order.
	assign AWREADY = !aw_have_q && !BVALID;
	assign WREADY = !w_have_q && !BVALID;
	assign do_write = aw_have_q && w_have_q && !BVALID;

	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end
		else if (AWVALID && AWREADY)
		begin
			aw_have_q <= 1'b1;
			aw_addr_q <= AWADDR;
		end
		else if (do_write)
			aw_have_q <= 1'b0;
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else if (WVALID && WREADY)
		begin
			w_have_q <= 1'b1;
			w_data_q <= WDATA;
			w_strb_q <= WSTRB;
		end
		else if (do_write)
			w_have_q <= 1'b0;
	end

	// Write response; unmapped addresses answer with a slave error.
	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			BVALID <= 1'b0;
			BRESP <= `RESP_OKAY;
		end
		else if (do_write)
		begin
			BVALID <= 1'b1;
			BRESP <= reg_known(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (BREADY)
			BVALID <= 1'b0;
	end

	// Configuration registers. The mask keeps reserved bits at zero and
	// pins bit 11 of channel 0, which has no split function.
	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			prescaler_select_q <= `PRESCALER_RESET;
			mode_q[0] <= `MODE_RESET;
			mode_q[1] <= `MODE_RESET;
			data_q[0] <= `DATA_RESET;
			data_q[1] <= `DATA_RESET;
		end
		else if (do_write)
		begin
			case (aw_addr_q)
				`OFS_PRESCALER: prescaler_select_q <=
					merge16(prescaler_select_q, w_data_q, w_strb_q);
				`OFS_CH0_MODE: mode_q[0] <= merge16(mode_q[0], w_data_q,
					w_strb_q) & `MODE_WMASK_CH0;
				`OFS_CH3_MODE: mode_q[1] <= merge16(mode_q[1], w_data_q,
					w_strb_q) & `MODE_WMASK_CH3;
				`OFS_CH0_DATA: data_q[0] <=
					merge16(data_q[0], w_data_q, w_strb_q);
				`OFS_CH3_DATA: data_q[1] <=
					merge16(data_q[1], w_data_q, w_strb_q);
				default: ;
			endcase
		end
	end

	// Software start is a one-cycle strobe; it never lingers as a level.
	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			sw_start_q <= '0;
		else if (do_write && aw_addr_q == `OFS_SW_START && w_strb_q[0])
			sw_start_q <= w_data_q[NCH-1:0];
		else
			sw_start_q <= '0;
	end

	// Read side: one read at a time, data registered on acceptance.
	assign ARREADY = !RVALID;

	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `RESP_OKAY;
		end
		else if (ARVALID && ARREADY)
		begin
			RVALID <= 1'b1;
			RRESP <= reg_known(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
			case (ARADDR)
				`OFS_PRESCALER: RDATA <= {16'h0000, prescaler_select_q};
				`OFS_CH0_MODE: RDATA <= {16'h0000, mode_q[0]};
				`OFS_CH3_MODE: RDATA <= {16'h0000, mode_q[1]};
				`OFS_CH0_DATA: RDATA <= {16'h0000, data_q[0]};
				`OFS_CH3_DATA: RDATA <= {16'h0000, data_q[1]};
				`OFS_STATUS: RDATA <= {24'h000000, stat[1], stat[0]};
				`OFS_COUNTERS: RDATA <= {count[1], count[0]};
				`OFS_CAPTURES: RDATA <= {capture[1], capture[0]};
				default: RDATA <= 32'h00000000;
			endcase
		end
		else if (RREADY)
			RVALID <= 1'b0;
	end

	// Free-running prescaler; each tap fires one cycle in 2^field.
	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			presc_q <= '0;
		else
			presc_q <= presc_q + 1'b1;
	end

	genvar t;
	generate
		for (t = 0; t < 4; t++)
		begin : g_tap
			assign tap_en[t] = tap_pulse(presc_q,
				prescaler_select_q[4*t +: 4]);
		end
	endgenerate

	assign pin = {CH3_TIMER_INPUT, CH0_TIMER_INPUT};

	// Pin synchronisers; the first stage feeds only the second.
	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end
		else
		begin
			sync1_q <= pin;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	genvar c;
	generate
		for (c = 0; c < NCH; c++)
		begin : g_ch
			assign cfg[c] = timer_mode_pkg::mode_reg_t'(mode_q[c]);
			assign rise[c] = sync2_q[c] && !prev_q[c];
			assign fall[c] = !sync2_q[c] && prev_q[c];

			// Edge field: 00 falling, 01 rising, others both edges.
			always_comb
			begin
				case (cfg[c].edge_sel)
					2'b00: valid_edge[c] = fall[c];
					2'b01: valid_edge[c] = rise[c];
					default: valid_edge[c] = rise[c] || fall[c];
				endcase
			end

			// Hardware trigger source; a prohibited code gives none.
			always_comb
			begin
				case (cfg[c].trig_sel)
					timer_mode_pkg::TRIG_EDGE: hw_trig[c] = valid_edge[c];
					timer_mode_pkg::TRIG_BOTH:
						hw_trig[c] = rise[c] || fall[c];
					timer_mode_pkg::TRIG_MASTER:
						hw_trig[c] = (c != 0) && stat[0].irq;
					default: hw_trig[c] = 1'b0;
				endcase
			end

			// Count clock: selected tap or the channel's own pin edges.
			assign count_en[c] = cfg[c].count_src_sel ? valid_edge[c] :
				tap_en[opclk_tap(cfg[c].opclk_sel)];

			timer_channel u_chan
			(
				.clk(SYS_CLK),
				.rst_n(RESET_N),
				.cfg(cfg[c]),
				.reload(data_q[c]),
				.tick(count_en[c]),
				.sw_start(sw_start_q[c]),
				.hw_trig(hw_trig[c]),
				.count(count[c]),
				.capture(capture[c]),
				.stat(stat[c])
			);
		end
	endgenerate

	assign CH0_TIMER_OUT = stat[0].out;
	assign CH3_TIMER_OUT = stat[1].out;
	assign CH0_TIMER_INT = stat[0].irq;
	assign CH3_TIMER_INT = stat[1].irq;

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	a_soft_trig_only: assert property (
		cfg[0].trig_sel == 3'b000 |-> !hw_trig[0])
		else $error("hardware trigger leaked in software-only setting");
	a_tap_swap: assert property (
		!cfg[0].count_src_sel && cfg[0].opclk_sel == 2'b01
		|-> count_en[0] == tap_en[2])
		else $error("channel 0 operation clock map wrong");
	a_edge_count: assert property (
		cfg[1].count_src_sel |-> count_en[1] == valid_edge[1])
		else $error("channel 3 did not count pin edges");
	a_split_fixed: assert property (!mode_q[0][11])
		else $error("channel 0 bit 11 not held at zero");
	a_both_edges: assert property (
		cfg[0].trig_sel == 3'b010 && $rose(sync2_q[0]) |-> hw_trig[0])
		else $error("both-edge trigger missed a rising edge");
	a_master_trig: assert property (
		cfg[1].trig_sel == 3'b100 |-> hw_trig[1] == stat[0].irq)
		else $error("slave did not follow master interrupt");
	a_tap1_rate: assert property (
		prescaler_select_q[7:4] == 4'h1 && tap_en[1] |=> !tap_en[1])
		else $error("tap 1 fired faster than its division");

endmodule
`default_nettype wire

// ==== timer_mode_defs.svh ====
`ifndef TIMER_MODE_DEFS_SVH
`define TIMER_MODE_DEFS_SVH

// Register byte offsets on the AXI4-Lite port.
`define OFS_PRESCALER 8'h00
`define OFS_CH0_MODE 8'h04
`define OFS_CH3_MODE 8'h08
`define OFS_SW_START 8'h0c
`define OFS_CH0_DATA 8'h10
`define OFS_CH3_DATA 8'h14
`define OFS_STATUS 8'h18
`define OFS_COUNTERS 8'h1c
`define OFS_CAPTURES 8'h20

// Writable bits of the two mode registers; bit 11 exists on channel 3 only.
`define MODE_WMASK_CH0 16'hd7cf
`define MODE_WMASK_CH3 16'hdfcf

// Reset values.
`define MODE_RESET 16'h0000
`define PRESCALER_RESET 16'h0000
`define DATA_RESET 16'h0000

// Prescaler length: tap field value 15 divides by two to the fifteenth.
`define PRESCALER_BITS 15

// Split operation keeps the counter to its low byte.
`define SPLIT_MASK 16'h00ff
`define FULL_MASK 16'hffff

// Bus responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== timer_mode_pkg.sv ====
package timer_mode_pkg;

	// Layout of one channel mode register, bit 15 first.
	typedef struct packed {
		logic [1:0] opclk_sel;
		logic rsv13;
		logic count_src_sel;
		logic width_split;
		logic [2:0] trig_sel;
		logic [1:0] edge_sel;
		logic [1:0] rsv5_4;
		logic [2:0] mode_field;
		logic mode_low_bit;
	} mode_reg_t;

	typedef enum logic [2:0] {
		MODE_INTERVAL = 3'b000,
		MODE_CAPTURE = 3'b001,
		MODE_EVENT = 3'b010,
		MODE_ONE_COUNT = 3'b011,
		MODE_CAP_ONE = 3'b100,
		MODE_BAD = 3'b111
	} op_mode_t;

	typedef enum logic [2:0] {
		TRIG_SOFT = 3'b000,
		TRIG_EDGE = 3'b001,
		TRIG_BOTH = 3'b010,
		TRIG_MASTER = 3'b100
	} trig_t;

	// Per-channel state as seen by software.
	typedef struct packed {
		logic counting;
		logic irq;
		logic out;
		logic prohibited;
	} chan_stat_t;

	// Maps the four mode bits to an operating mode or to MODE_BAD.
	function automatic op_mode_t decode_mode(input mode_reg_t r);
		case ({r.mode_field, r.mode_low_bit})
			4'h0, 4'h1: decode_mode = MODE_INTERVAL;
			4'h4, 4'h5: decode_mode = MODE_CAPTURE;
			4'h6: decode_mode = MODE_EVENT;
			4'h8, 4'h9: decode_mode = MODE_ONE_COUNT;
			4'hc: decode_mode = MODE_CAP_ONE;
			default: decode_mode = MODE_BAD;
		endcase
	endfunction

	// True when the trigger field holds one of the four usable codes.
	function automatic logic trig_ok(input mode_reg_t r);
		trig_ok = (r.trig_sel == TRIG_SOFT) || (r.trig_sel == TRIG_EDGE) ||
			(r.trig_sel == TRIG_BOTH) || (r.trig_sel == TRIG_MASTER);
	endfunction

endpackage
